// file: rtl/srcrs_consts.svh
/*
 * Constants of the reset and clock-ready sequencer: register offsets,
 * field positions, reset values and delay figures with their cycle counts.
 * Assumes a 10 MHz system clock and byte addresses on a 32-bit APB.
 */
`ifndef SRCRS_CONSTS_SVH
`define SRCRS_CONSTS_SVH

`define SRCRS_CLK_MHZ          10
`define SRCRS_CLK_NS           100

`define SRCRS_POR_EXT_US       30
`define SRCRS_POR_EXT_CYC      (`SRCRS_POR_EXT_US * `SRCRS_CLK_MHZ)
`define SRCRS_BOR_EXT_US       100
`define SRCRS_BOR_EXT_CYC      (`SRCRS_BOR_EXT_US * `SRCRS_CLK_MHZ)
`define SRCRS_FRC_OSCD_NS      1100
`define SRCRS_FRC_OSCD_CYC     (`SRCRS_FRC_OSCD_NS / `SRCRS_CLK_NS)
`define SRCRS_LOW_POWER_INTERNAL_RC_OSCD_US     70
`define SRCRS_LOW_POWER_INTERNAL_RC_OSCD_CYC    (`SRCRS_LOW_POWER_INTERNAL_RC_OSCD_US * `SRCRS_CLK_MHZ)
`define SRCRS_XTAL_OSCD_US     70
`define SRCRS_XTAL_OSCD_CYC    (`SRCRS_XTAL_OSCD_US * `SRCRS_CLK_MHZ)
`define SRCRS_OST_PERIODS      1024
`define SRCRS_LOCK_US          1500
`define SRCRS_LOCK_CYC         (`SRCRS_LOCK_US * `SRCRS_CLK_MHZ)
`define SRCRS_MON_US           900
`define SRCRS_MON_CYC          (`SRCRS_MON_US * `SRCRS_CLK_MHZ)
`define SRCRS_MS_CYC           (1000 * `SRCRS_CLK_MHZ)

`define SRCRS_RCS_OFF          12'h000
`define SRCRS_OSCCTL_OFF       12'h004
`define SRCRS_SEQSTAT_OFF      12'h008

`define SRCRS_RCS_POR          0
`define SRCRS_RCS_BOR          1
`define SRCRS_RCS_IDLE         2
`define SRCRS_RCS_SWDT         5
`define SRCRS_RCS_SWR          6
`define SRCRS_RCS_WARM         7
`define SRCRS_RCS_RESET        16'h0003
`define SRCRS_RCS_WMASK        16'h00e7
`define SRCRS_CURRENT_OSCILLATOR_FIELD_LSB         12
`define SRCRS_RESET_VECTOR     24'h000000

`endif

// file: rtl/srcrs_pkg.sv
/*
 * Types of the reset and clock-ready sequencer: sequence states,
 * oscillator selections and the primary oscillator kinds.
 * Assumes nothing of its surroundings.
 */
package srcrs_pkg;

    typedef enum logic [10:0] {
        ST_POR_WAIT = 11'h001,
        ST_POR_EXT  = 11'h002,
        ST_BOR_WAIT = 11'h004,
        ST_BOR_EXT  = 11'h008,
        ST_POWER_UP_TIMER     = 11'h010,
        ST_OSCD     = 11'h020,
        ST_OST      = 11'h040,
        ST_LOCK     = 11'h080,
        ST_RUN      = 11'h100,
        ST_WARM     = 11'h200,
        ST_SWR      = 11'h400
    } srcrs_state_e;

    typedef enum logic [2:0] {
        OSC_FRC     = 3'h0,
        OSC_FRC_PLL = 3'h1,
        OSC_PRI     = 3'h2,
        OSC_PRI_PLL = 3'h3,
        OSC_SEC     = 3'h4,
        OSC_LOW_POWER_INTERNAL_RC    = 3'h5,
        OSC_FRC_D16 = 3'h6,
        OSC_FRC_DN  = 3'h7
    } srcrs_osc_e;

    typedef enum logic [1:0] {
        PRI_EXT_CLK = 2'h0,
        PRI_MED_XTL = 2'h1,
        PRI_HS_XTL  = 2'h2
    } srcrs_pri_e;

endpackage : srcrs_pkg

// file: rtl/srcrs_top.sv
/*
 * Reset and clock-ready sequencer: supply supervision, power-up timer,
 * oscillator ready delays, cold/warm reset handling, reset-cause register.
 * Assumes supply comparators and reset requests synchronous to clk_sys,
 * osc_tick one cycle high per oscillator period, APB master on one clock.
 */
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "srcrs_consts.svh"

// Functional notes
// RL1: idle wake-up flag set after idle state
// RL2: brown-out sets cause flag bit 1
// RL3: power-on sets cause flag bit 0
// RL4: flags writable; writes never cause reset
// RL5: nonvolatile enable forces watchdog on
// RL6: cold reset takes configured new oscillator
// RL7: warm reset keeps current oscillator field
// RL8: hold reset until supplies and clock ready; code releases reset after the power-up timer, before the clock delays
// RL9: clock-ready delay chosen per oscillator mode
// RL10: start-up timer counts 1024 oscillator periods
// RL11: PLL modes add lock wait
// RL12: start-up delay within 1.1 or 70 us
// RL13: power-up timer 0-128 ms after brown-out
// RL14: power-on extension at most 30 us
// RL15: brown-out extension at most 100 us
// RL16: execution starts at address zero
// RL17: clock monitor starts 900 us after ready
// RL18: any active source asserts system reset; code ignores warm and software requests during the clock delays
// RL19: power-on clears other flags, sets its own
// RL20: software reset releases next cycle, clock kept
// RL21: delays counted on clk_sys, clock after release
module srcrs_top
    import srcrs_pkg::*;
#(
    parameter int          APB_AW      = 12,
    parameter logic [31:0] LOCK_CYC    = `SRCRS_LOCK_CYC,
    parameter logic [31:0] MON_CYC     = `SRCRS_MON_CYC,
    parameter logic [31:0] POWER_UP_TIMER_MS_CYC = `SRCRS_MS_CYC
)(
    input  wire logic              clk_sys,
    input  wire logic              reset,
    input  wire logic [APB_AW-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              por_supply_ok,
    input  wire logic              bor_supply_ok,
    input  wire logic              warm_reset_req,
    input  wire logic              soft_reset_instr,
    input  wire logic              idle_entered,
    input  wire logic              osc_tick,
    input  wire logic              nv_watchdog_enable,
    input  wire logic [2:0]        new_oscillator_select,
    input  wire logic [1:0]        primary_kind,
    input  wire logic [2:0]        power_up_select,
    input  wire logic              monitor_enable,
    output logic                   system_reset_line,
    output logic                   clock_ready,
    output logic                   fetch_start,
    output logic [23:0]            fetch_address,
    output logic [2:0]             active_oscillator,
    output logic                   watchdog_enable,
    output logic                   monitor_active
);

    typedef struct packed {
        srcrs_state_e state;
        logic [31:0]  cnt;
        logic [31:0]  mon_cnt;
        logic [15:0]  rcs;
        srcrs_osc_e   cur_osc;
        logic         sys_rst;
        logic         clk_rdy;
        logic         fetch;
        logic [23:0]  fetch_addr;
        logic         mon_on;
        logic         wdt_en;
        logic         pready;
        logic         pslverr;
        logic [31:0]  prdata;
    } srcrs_regs_s;

    localparam srcrs_regs_s RST = '{
        state:      ST_POR_WAIT,
        cnt:        32'h0,
        mon_cnt:    32'h0,
        rcs:        `SRCRS_RCS_RESET,
        cur_osc:    OSC_FRC,
        sys_rst:    1'b1,
        clk_rdy:    1'b0,
        fetch:      1'b0,
        fetch_addr: `SRCRS_RESET_VECTOR,
        mon_on:     1'b0,
        wdt_en:     1'b1,
        pready:     1'b0,
        pslverr:    1'b0,
        prdata:     32'h0
    };

    srcrs_regs_s st;
    srcrs_regs_s next_st;

    // crystal and secondary sources need the start-up timer
    function automatic logic needs_ost(srcrs_osc_e o, logic [1:0] k);
        if (o == OSC_SEC)
            return 1'b1;
        if (o == OSC_PRI || o == OSC_PRI_PLL)
            return k != PRI_EXT_CLK;
        return 1'b0;
    endfunction : needs_ost

    function automatic logic needs_lock(srcrs_osc_e o);
        return o == OSC_FRC_PLL || o == OSC_PRI_PLL;
    endfunction : needs_lock

    // longest figures rounded down to whole cycles
    function automatic logic [31:0] oscd_cyc(srcrs_osc_e o,
                                             logic [1:0] k);
        case (o)
            OSC_LOW_POWER_INTERNAL_RC:
                return 32'(`SRCRS_LOW_POWER_INTERNAL_RC_OSCD_CYC);
            OSC_SEC:
                return 32'(`SRCRS_XTAL_OSCD_CYC);
            OSC_PRI, OSC_PRI_PLL:
                return (k == PRI_EXT_CLK) ? 32'h0
                                          : 32'(`SRCRS_XTAL_OSCD_CYC);
            default:
                return 32'(`SRCRS_FRC_OSCD_CYC);
        endcase
    endfunction : oscd_cyc

    // eight power-up settings, 0 to 128 ms
    function automatic logic [31:0] power_up_timer_cyc(logic [2:0] sel);
        logic [7:0] ms;
        ms = (sel == 3'h0) ? 8'h0 : 8'(8'h1 << sel);
        return 32'(ms * POWER_UP_TIMER_MS_CYC);
    endfunction : power_up_timer_cyc

    logic        apb_acc;
    logic        apb_hit;
    logic [31:0] rd_word;

    assign apb_acc = psel && penable;

    always_comb
    begin
        apb_hit = 1'b1;
        rd_word = 32'h0;
        case (paddr)
            `SRCRS_RCS_OFF:
                rd_word = {16'h0, st.rcs};
            `SRCRS_OSCCTL_OFF:
                rd_word = 32'(st.cur_osc) << `SRCRS_CURRENT_OSCILLATOR_FIELD_LSB;
            `SRCRS_SEQSTAT_OFF:
                rd_word = {st.mon_on, st.clk_rdy, st.sys_rst, 18'h0,
                           st.state};
            default:
                apb_hit = 1'b0;
        endcase
    end

    always_comb
    begin
        next_st = st;
        next_st.fetch = 1'b0;

        // one wait state; write lands at the edge that sees pready
        next_st.pready = apb_acc && !st.pready;
        next_st.pslverr = apb_acc && !st.pready && !apb_hit;
        if (apb_acc && !st.pready)
            next_st.prdata = pwrite ? 32'h0 : rd_word;
        if (apb_acc && st.pready && pwrite && apb_hit
            && paddr == `SRCRS_RCS_OFF)
            next_st.rcs = pwdata[15:0] & `SRCRS_RCS_WMASK; // [RL4]

        // hardware sets follow the bus write so a set is never lost
        if (idle_entered)
            next_st.rcs[`SRCRS_RCS_IDLE] = 1'b1; // [RL1]

        if (st.cnt != 32'h0)
            next_st.cnt = st.cnt - 32'h1;

        if (!por_supply_ok && st.state != ST_POR_WAIT)
        begin
            next_st.state = ST_POR_WAIT; // [RL18]
            next_st.sys_rst = 1'b1;
            next_st.clk_rdy = 1'b0;
            next_st.mon_on = 1'b0;
            next_st.rcs = 16'h0;
            next_st.rcs[`SRCRS_RCS_POR] = 1'b1; // [RL3] [RL19]
        end
        else if (!bor_supply_ok && st.state != ST_POR_WAIT
                 && st.state != ST_POR_EXT && st.state != ST_BOR_WAIT)
        begin
            next_st.state = ST_BOR_WAIT; // [RL18]
            next_st.sys_rst = 1'b1;
            next_st.clk_rdy = 1'b0;
            next_st.mon_on = 1'b0;
            next_st.rcs[`SRCRS_RCS_BOR] = 1'b1; // [RL2]
            next_st.rcs[`SRCRS_RCS_SWR] = 1'b0;
        end
        else
        begin
            case (st.state)
                ST_POR_WAIT:
                    if (por_supply_ok)
                    begin
                        next_st.state = ST_POR_EXT;
                        next_st.cnt = 32'(`SRCRS_POR_EXT_CYC); // [RL14]
                    end
                ST_POR_EXT:
                    if (st.cnt == 32'h0)
                        next_st.state = ST_BOR_WAIT;
                ST_BOR_WAIT:
                    if (bor_supply_ok)
                    begin
                        next_st.state = ST_BOR_EXT;
                        next_st.cnt = 32'(`SRCRS_BOR_EXT_CYC); // [RL15]
                    end
                ST_BOR_EXT:
                    if (st.cnt == 32'h0)
                    begin
                        next_st.state = ST_POWER_UP_TIMER;
                        next_st.cnt = power_up_timer_cyc(power_up_select); // [RL13]
                    end
                ST_POWER_UP_TIMER:
                    if (st.cnt == 32'h0)
                    begin
                        // cold path: release reset, then time the clock
                        next_st.state = ST_OSCD; // [RL13] [RL21]
                        next_st.sys_rst = 1'b0;
                        next_st.cur_osc =
                            srcrs_osc_e'(new_oscillator_select); // [RL6]
                        next_st.cnt = oscd_cyc(
                            srcrs_osc_e'(new_oscillator_select),
                            primary_kind); // [RL12]
                    end
                ST_OSCD:
                    if (st.cnt == 32'h0)
                    begin
                        if (needs_ost(st.cur_osc, primary_kind))
                        begin
                            next_st.state = ST_OST; // [RL9]
                            next_st.cnt = 32'(`SRCRS_OST_PERIODS);
                        end
                        else if (needs_lock(st.cur_osc))
                        begin
                            next_st.state = ST_LOCK; // [RL9]
                            next_st.cnt = LOCK_CYC;
                        end
                        else
                            next_st.state = ST_RUN;
                    end
                ST_OST:
                begin
                    // counts oscillator periods, not system cycles
                    next_st.cnt = (osc_tick && st.cnt != 32'h0)
                                  ? st.cnt - 32'h1 : st.cnt; // [RL10]
                    if (st.cnt == 32'h0)
                    begin
                        if (needs_lock(st.cur_osc))
                        begin
                            next_st.state = ST_LOCK; // [RL9]
                            next_st.cnt = LOCK_CYC; // [RL11]
                        end
                        else
                            next_st.state = ST_RUN;
                    end
                end
                ST_LOCK:
                    if (st.cnt == 32'h0)
                        next_st.state = ST_RUN; // [RL11]
                ST_RUN:
                begin
                    if (warm_reset_req)
                    begin
                        next_st.state = ST_WARM; // [RL18] [RL7]
                        next_st.sys_rst = 1'b1;
                        next_st.rcs[`SRCRS_RCS_WARM] = 1'b1;
                    end
                    else if (soft_reset_instr)
                    begin
                        next_st.state = ST_SWR; // [RL20]
                        next_st.sys_rst = 1'b1;
                        next_st.rcs[`SRCRS_RCS_SWR] = 1'b1;
                    end
                end
                ST_WARM:
                    if (!warm_reset_req)
                    begin
                        next_st.state = ST_RUN; // [RL18]
                        next_st.sys_rst = 1'b0;
                        next_st.fetch = 1'b1;
                        next_st.fetch_addr = `SRCRS_RESET_VECTOR;
                    end
                ST_SWR:
                begin
                    next_st.state = ST_RUN; // [RL20]
                    next_st.sys_rst = 1'b0;
                    next_st.fetch = 1'b1;
                    next_st.fetch_addr = `SRCRS_RESET_VECTOR; // [RL16]
                end
                default:
                    next_st.state = ST_POR_WAIT;
            endcase

            // first arrival in run after a cold sequence
            if (next_st.state == ST_RUN && !st.clk_rdy)
            begin
                next_st.clk_rdy = 1'b1; // [RL8]
                next_st.fetch = 1'b1;
                next_st.fetch_addr = `SRCRS_RESET_VECTOR; // [RL16]
                next_st.mon_cnt = MON_CYC; // [RL17]
            end
        end

        // monitor delay keeps running across warm resets
        if (st.clk_rdy && next_st.clk_rdy && st.mon_cnt != 32'h0)
            next_st.mon_cnt = st.mon_cnt - 32'h1;
        next_st.mon_on = next_st.clk_rdy && monitor_enable
                         && st.clk_rdy && st.mon_cnt == 32'h0; // [RL17]

        next_st.wdt_en = nv_watchdog_enable
                         || next_st.rcs[`SRCRS_RCS_SWDT]; // [RL5]
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            st <= RST;
        else
            st <= next_st;
    end

    assign prdata            = st.prdata;
    assign pready            = st.pready;
    assign pslverr           = st.pslverr;
    assign system_reset_line = st.sys_rst;
    assign clock_ready       = st.clk_rdy;
    assign fetch_start       = st.fetch;
    assign fetch_address     = st.fetch_addr;
    assign active_oscillator = st.cur_osc;
    assign watchdog_enable   = st.wdt_en;
    assign monitor_active    = st.mon_on;

endmodule : srcrs_top
`default_nettype wire

// file: bench/srcrs_properties.sv
/*
 * srcrs_checker: concurrent checks on the sequencer's top-level ports.
 * Assumes APB requests held until pready and clk_sys as the only clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "srcrs_consts.svh"
module srcrs_checker (
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire logic [11:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        por_supply_ok,
    input wire logic        warm_reset_req,
    input wire logic        soft_reset_instr,
    input wire logic        nv_watchdog_enable,
    input wire logic        monitor_enable,
    input wire logic        system_reset_line,
    input wire logic        clock_ready,
    input wire logic        fetch_start,
    input wire logic [23:0] fetch_address,
    input wire logic        watchdog_enable,
    input wire logic        monitor_active
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_apb_one_wait: assert property ((psel && !penable) ##1 (psel && penable)
        |-> !pready ##1 pready) else $error("apb wait state wrong");
    a_unmapped_err: assert property (pready |-> pslverr ==
        !(paddr inside {12'h000, 12'h004, 12'h008}))
        else $error("slave error mismatch");
    a_por_holds: assert property (!por_supply_ok |=>
        system_reset_line) else $error("power-on did not hold reset");
    a_ready_after_release: assert property (
        $rose(clock_ready) |-> !system_reset_line && fetch_start)
        else $error("ready before release");
    a_fetch_vector: assert property (fetch_start |->
        !system_reset_line && fetch_address == `SRCRS_RESET_VECTOR)
        else $error("bad fetch vector");
    a_soft_pulse: assert property (soft_reset_instr && clock_ready &&
        !system_reset_line && !warm_reset_req |=> system_reset_line ##1
        (!system_reset_line && fetch_start)) else $error("soft reset timing");
    a_warm_asserts: assert property (warm_reset_req && clock_ready
        |=> system_reset_line) else $error("warm reset not asserted");
    a_wdt_forced: assert property (nv_watchdog_enable |=>
        watchdog_enable) else $error("watchdog not forced on");
    a_monitor_delay: assert property ($rose(clock_ready) &&
        monitor_enable |-> !monitor_active[*8])
        else $error("monitor started early");
endmodule : srcrs_checker

bind srcrs_top srcrs_checker srcrs_checker_inst (.clk_sys(clk_sys),
    .reset(reset), .paddr(paddr), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .por_supply_ok(por_supply_ok),
    .warm_reset_req(warm_reset_req), .soft_reset_instr(soft_reset_instr),
    .nv_watchdog_enable(nv_watchdog_enable),
    .monitor_enable(monitor_enable), .system_reset_line(system_reset_line),
    .clock_ready(clock_ready), .fetch_start(fetch_start),
    .fetch_address(fetch_address), .watchdog_enable(watchdog_enable),
    .monitor_active(monitor_active));
`default_nettype wire

// file: bench/tb.sv
/*
 * tb: self-checking bench of the sequencer, cold boots per clock mode,
 * warm, soft and brown-out resets, reset-cause register over APB.
 * Assumes shortened lock, monitor and millisecond counts via parameters.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import srcrs_pkg::*;
    logic        clk_sys = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic        pready, pslverr, err, osc_tick = 0, idle_entered = 0;
    logic        por_supply_ok = 0, bor_supply_ok = 0, warm_reset_req = 0;
    logic        soft_reset_instr = 0, nv_watchdog_enable = 1;
    logic        monitor_enable = 1, system_reset_line, clock_ready;
    logic [2:0]  new_oscillator_select = 0, power_up_select = 0;
    logic [2:0]  active_oscillator;
    logic [1:0]  primary_kind = 0;
    logic        fetch_start, watchdog_enable, monitor_active;
    logic [23:0] fetch_address;
    // the bench's reset leaves both supply flags at their reset value
    logic [31:0] por_flags = 32'h3;
    int          failures = 0, checks = 0;

    srcrs_top #(.LOCK_CYC(20), .MON_CYC(30), .POWER_UP_TIMER_MS_CYC(5)) srcrs_top_inst (
        .clk_sys(clk_sys), .reset(reset), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .por_supply_ok(por_supply_ok), .bor_supply_ok(bor_supply_ok),
        .warm_reset_req(warm_reset_req), .soft_reset_instr(soft_reset_instr),
        .idle_entered(idle_entered), .osc_tick(osc_tick),
        .nv_watchdog_enable(nv_watchdog_enable),
        .new_oscillator_select(new_oscillator_select),
        .primary_kind(primary_kind), .power_up_select(power_up_select),
        .monitor_enable(monitor_enable),
        .system_reset_line(system_reset_line), .clock_ready(clock_ready),
        .fetch_start(fetch_start), .fetch_address(fetch_address),
        .active_oscillator(active_oscillator),
        .watchdog_enable(watchdog_enable), .monitor_active(monitor_active));

    initial
    begin
        forever #50 clk_sys = ~clk_sys;
    end
    // oscillator period of two system cycles: 1024 periods take 2048
    always @(posedge clk_sys) osc_tick <= ~osc_tick;

    task automatic chk(input string what, input logic [31:0] exp, got);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd);
        int n = 0;
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1;
        do
        begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        chk("pready", 1, n < 20);
        // idle cycle so a following call never re-drives psel in this step
        @(posedge clk_sys);
    endtask : apb

    task automatic boot(input logic [2:0] osc, input logic [1:0] kind,
                        input logic [2:0] pw, input int dly);
        int n = 0;
        int e = 1300 + (pw == 0 ? 0 : (1 << pw)) * 5;
        new_oscillator_select <= osc;
        primary_kind <= kind;
        power_up_select <= pw;
        por_supply_ok <= 0;
        bor_supply_ok <= 0;
        repeat (3) @(posedge clk_sys);
        chk("reset held", 1, system_reset_line);
        por_supply_ok <= 1;
        bor_supply_ok <= 1;
        while (system_reset_line !== 1'b0 && n < 3000)
        begin
            @(posedge clk_sys);
            n++;
        end
        chk("release time", 1, n >= e && n <= e + 8);
        n = 0;
        while (clock_ready !== 1'b1 && n < 4000)
        begin
            @(posedge clk_sys);
            n++;
        end
        chk("ready time", 1, n >= dly && n <= dly + 8);
        chk("fetch", 1, fetch_start);
        chk("cold osc", osc, active_oscillator);
        apb(0, 12'h000, 0);
        chk("por flags", por_flags, rd);
        por_flags = 32'h1;
        repeat (40) @(posedge clk_sys);
        chk("monitor", 1, monitor_active);
        $display("test boot %0d done", osc);
    endtask : boot

    task automatic regs;
        apb(1, 12'h000, 32'hffff);
        chk("no reset on write", 0, system_reset_line);
        apb(0, 12'h000, 0);
        chk("status ones", 32'h00e7, rd);
        apb(1, 12'h000, 0);
        apb(0, 12'h000, 0);
        chk("status zero", 0, rd);
        nv_watchdog_enable <= 0;
        repeat (3) @(posedge clk_sys);
        chk("wdt off", 0, watchdog_enable);
        nv_watchdog_enable <= 1;
        apb(0, 12'h00c, 0);
        chk("unmapped err", 1, err);
        chk("unmapped data", 0, rd);
        apb(0, 12'h008, 0);
        chk("sequencer status", 32'hc000_0100, rd);
        monitor_enable <= 0;
        repeat (2) @(posedge clk_sys);
        chk("monitor off", 0, monitor_active);
        monitor_enable <= 1;
        idle_entered <= 1;
        @(posedge clk_sys);
        idle_entered <= 0;
        apb(0, 12'h000, 0);
        chk("idle flag", 32'h4, rd);
        $display("test registers done");
    endtask : regs

    task automatic resets;
        soft_reset_instr <= 1;
        @(posedge clk_sys);
        soft_reset_instr <= 0;
        repeat (4) @(posedge clk_sys);
        apb(0, 12'h004, 0);
        chk("soft keeps osc", {17'h0, 3'(OSC_FRC_DN), 12'h0}, rd);
        apb(0, 12'h000, 0);
        chk("soft flag", 32'h40, rd & 32'h40);
        warm_reset_req <= 1;
        repeat (4) @(posedge clk_sys);
        chk("warm held", 1, system_reset_line);
        warm_reset_req <= 0;
        repeat (4) @(posedge clk_sys);
        chk("warm released", 0, system_reset_line);
        apb(0, 12'h000, 0);
        chk("warm flag", 32'h80, rd & 32'h80);
        bor_supply_ok <= 0;
        repeat (3) @(posedge clk_sys);
        chk("brown-out held", 1, system_reset_line);
        bor_supply_ok <= 1;
        repeat (1100) @(posedge clk_sys);
        chk("brown-out ready", 1, clock_ready);
        apb(0, 12'h000, 0);
        chk("brown-out flags", 32'h2, rd & 32'h42);
        $display("test resets done");
    endtask : resets

    task automatic summarize;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize

    initial
    begin
        repeat (60000) @(posedge clk_sys);
        failures++;
        summarize();
    end

    initial
    begin
        repeat (12) @(posedge clk_sys);
        reset <= 0;
        @(posedge clk_sys);
        chk("reset line", 1, system_reset_line);
        apb(0, 12'h000, 0);
        chk("status reset", 32'h3, rd);
        boot(OSC_FRC, PRI_EXT_CLK, 3'h0, 11);
        boot(OSC_FRC_PLL, PRI_EXT_CLK, 3'h7, 31);
        boot(OSC_PRI, PRI_EXT_CLK, 3'h1, 0);
        boot(OSC_PRI_PLL, PRI_EXT_CLK, 3'h0, 20);
        boot(OSC_PRI, PRI_MED_XTL, 3'h0, 2748);
        boot(OSC_PRI_PLL, PRI_HS_XTL, 3'h0, 2768);
        boot(OSC_SEC, PRI_EXT_CLK, 3'h0, 2748);
        boot(OSC_LOW_POWER_INTERNAL_RC, PRI_EXT_CLK, 3'h0, 700);
        boot(OSC_FRC_D16, PRI_EXT_CLK, 3'h0, 11);
        boot(OSC_FRC_DN, PRI_EXT_CLK, 3'h0, 11);
        regs();
        resets();
        summarize();
    end
endmodule : tb
`default_nettype wire
